// ==== switch_prio_stats_regs.svh ====
// register offsets, field positions, reset values and constants of the switch engine register bank
`ifndef SWITCH_PRIO_STATS_REGS_SVH
`define SWITCH_PRIO_STATS_REGS_SVH
// ==========================================
// register offsets (register index on the plain port)
`define PORT0_PRIORITY_REGEN_MAP 16'h1855
`define PORT1_PRIORITY_REGEN_MAP 16'h1856
`define PORT2_PRIORITY_REGEN_MAP 16'h1857
`define PORT0_LEARN_DROP_COUNT 16'h1858
`define PORT1_LEARN_DROP_COUNT 16'h1859
`define PORT2_LEARN_DROP_COUNT 16'h185a
`define SWITCH_IRQ_MASK 16'h1880
`define SWITCH_IRQ_PENDING 16'h1881
`define ENGINE_EVENT_STATUS 16'h1882
`define ENGINE_EVENT_ENABLE 16'h1883
// ==========================================
// field positions
`define MAP_FIELD_W 3
`define MAP_USED_W 24
`define MASK_BIT 0
`define PEND_A_VALID 1
`define PEND_A_PORT_LSB 2
`define PEND_A_REASON_LSB 4
`define PEND_B_VALID 8
`define PEND_B_PORT_LSB 9
`define PEND_B_REASON_LSB 11
`define EVT_DROP_BIT 0
`define EVT_LEARN_BIT 1
`define EVT_SAT_BIT 2
`define EVT_W 3
// ==========================================
// reset values
`define MAP_RESET 24'hfac688
`define COUNT_RESET 32'h00000000
`define COUNT_MAX 32'hffffffff
`define MASK_RESET 1'h1
`define EVT_ENABLE_RESET 3'h0
`endif

// ==== switch_prio_stats_pkg.sv ====
// types shared by the switch engine register bank
package switch_prio_stats_pkg;
   // ==========================================
   // types
   typedef logic [2:0] prio_t;
   typedef logic [1:0] port_id_t;
   typedef logic [3:0] drop_reason_t;
   // received priority tagged with a valid strobe
   typedef struct packed {
      logic valid;
      prio_t prio;
   } prio_req_t;
   // one captured drop of the forwarding engine
   typedef struct packed {
      logic valid;
      port_id_t port;
      drop_reason_t reason;
   } drop_evt_t;
   // one half of the double-buffered pending status
   typedef struct packed {
      drop_reason_t reason;
      port_id_t port;
      logic valid;
   } pend_set_t;
endpackage

// ==== switch_prio_stats.sv ====
// switch engine priority regeneration, learn discard counters and interrupt mask
//
// What this block does
// - each port maps received priority through its table
// - queue selection gets regenerated, not raw, priority
// - eight 3-bit fields, priority n at 3n+2:3n
// - after reset each field holds its index
// - map bits 31:24 reserved, read only
// - per-port 32-bit counter counts learn discards
// - counter reads return value, clear; reset zero
// - counter saturates at all ones, no wrap
// - mask bit set blocks interrupts; reset set
// - clearing mask lets pending interrupts signal
// - pending status captured whatever the mask
// - mask register bits 31:1 reserved, read only
// - pending status double buffered, all masked globally
`timescale 1ns/1ps
`include "switch_prio_stats_regs.svh"

module switch_prio_stats
   import switch_prio_stats_pkg::*;
#(
   parameter int PORTS = 3
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // received priorities and regenerated priorities for queue selection
   input wire prio_req_t [PORTS-1:0] i_rx_prio,
   output prio_req_t [PORTS-1:0] o_queue_prio,
   // events from the learning and forwarding engines
   input wire logic [PORTS-1:0] i_learn_discard,
   input wire drop_evt_t i_drop,
   // interrupt
   output logic o_irq
);

   // ==========================================
   // register state
   // tables and counters are arrays indexed by port, so the per-port logic is one loop
   logic [`MAP_USED_W-1:0] map_r [PORTS];
   logic [`MAP_USED_W-1:0] map_nxt [PORTS];
   logic [31:0] cnt_r [PORTS];
   logic [31:0] cnt_nxt [PORTS];
   prio_req_t [PORTS-1:0] queue_prio_r;
   prio_req_t [PORTS-1:0] queue_prio_nxt;
   logic mask_r;
   logic mask_nxt;
   pend_set_t pend_a_r;
   pend_set_t pend_a_nxt;
   pend_set_t pend_b_r;
   pend_set_t pend_b_nxt;
   logic [`EVT_W-1:0] evt_r;
   logic [`EVT_W-1:0] evt_nxt;
   logic [`EVT_W-1:0] evt_en_r;
   logic [`EVT_W-1:0] evt_en_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [PORTS-1:0] sat_hit;

   // decode of the pending register read, which clears both sets
   logic pend_rd;
   assign pend_rd = i_rd && (i_addr == `SWITCH_IRQ_PENDING);

   // ==========================================
   // per-port table, lookup and counter
   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         localparam logic [15:0] MAP_ADDR = `PORT0_PRIORITY_REGEN_MAP + 16'(p);
         localparam logic [15:0] CNT_ADDR = `PORT0_LEARN_DROP_COUNT + 16'(p);

         // the upper byte has no storage, so it always reads zero and ignores writes
         // table write; upper byte not stored
         always_comb begin
            map_nxt[p] = map_r[p];
            if (i_wr && (i_addr == MAP_ADDR)) begin
               map_nxt[p] = i_wdata[`MAP_USED_W-1:0];
            end
         end

         // the lookup is registered, so queue selection never sees a half-written table
         // priority lookup for queue selection
         always_comb begin
            queue_prio_nxt[p].valid = i_rx_prio[p].valid;
            queue_prio_nxt[p].prio = map_r[p][`MAP_FIELD_W*i_rx_prio[p].prio +: `MAP_FIELD_W];
         end

         // a read and a discard in one cycle: the read returns the old count and
         // the discard opens the new one, so no event is lost across a clear
         // saturating clear-on-read counter
         always_comb begin
            cnt_nxt[p] = cnt_r[p];
            if (i_rd && (i_addr == CNT_ADDR)) begin
               cnt_nxt[p] = i_learn_discard[p] ? 32'h00000001 : `COUNT_RESET;
            end else if (i_learn_discard[p] && (cnt_r[p] != `COUNT_MAX)) begin
               cnt_nxt[p] = cnt_r[p] + 32'h00000001;
            end
         end
         assign sat_hit[p] = i_learn_discard[p] && (cnt_r[p] == `COUNT_MAX);

         // identity map and zero count at reset
         always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               map_r[p] <= `MAP_RESET;
               cnt_r[p] <= `COUNT_RESET;
               queue_prio_r[p] <= '0;
            end else begin
               map_r[p] <= map_nxt[p];
               cnt_r[p] <= cnt_nxt[p];
               queue_prio_r[p] <= queue_prio_nxt[p];
            end
         end

         regen_lookup_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            i_rx_prio[p].valid |=> o_queue_prio[p].valid
               && o_queue_prio[p].prio == $past(map_r[p][3*i_rx_prio[p].prio +: 3]))
            else $error("regenerated priority does not match table");

         count_sat_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            (cnt_r[p] == 32'hffffffff) && !(i_rd && i_addr == CNT_ADDR) |=> cnt_r[p] == 32'hffffffff)
            else $error("learn discard counter wrapped");

         count_inc_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            i_learn_discard[p] && !i_rd && (cnt_r[p] != 32'hffffffff) |=> cnt_r[p] == $past(cnt_r[p]) + 32'h1)
            else $error("learn discard not counted");

         // read returns old value and clears
         sequence cnt_read_s;
            i_rd && (i_addr == CNT_ADDR);
         endsequence
         count_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            cnt_read_s |=> (o_rdata == $past(cnt_r[p])) && (cnt_r[p] == {31'h0, $past(i_learn_discard[p])}))
            else $error("clear on read of counter wrong");

         // table write keeps the low three bytes
         map_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            i_wr && (i_addr == MAP_ADDR) |=> map_r[p] == $past(i_wdata[23:0]))
            else $error("regeneration table write not stored");

         map_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            !(i_wr && (i_addr == MAP_ADDR)) |=> $stable(map_r[p]))
            else $error("regeneration table changed without a write");

         // no queue request without a received priority
         queue_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            !i_rx_prio[p].valid |=> !o_queue_prio[p].valid)
            else $error("queue priority valid without received priority");

         // counter holds without event or read
         count_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
            !i_learn_discard[p] && !(i_rd && (i_addr == CNT_ADDR)) |=> $stable(cnt_r[p]))
            else $error("learn discard counter changed without cause");
      end
   endgenerate

   // ==========================================
   // mask, double-buffered pending status and event status
   always_comb begin
      mask_nxt = mask_r;
      evt_en_nxt = evt_en_r;
      pend_a_nxt = pend_a_r;
      pend_b_nxt = pend_b_r;
      evt_nxt = evt_r;
      // the mask gates only the line: status and pending capture run on regardless
      // only bit 0 of the mask is stored
      if (i_wr && (i_addr == `SWITCH_IRQ_MASK)) begin
         mask_nxt = i_wdata[`MASK_BIT];
      end
      if (i_wr && (i_addr == `ENGINE_EVENT_ENABLE)) begin
         evt_en_nxt = i_wdata[`EVT_W-1:0];
      end
      // write one to clear; a new event below wins
      if (i_wr && (i_addr == `ENGINE_EVENT_STATUS)) begin
         evt_nxt = evt_r & ~i_wdata[`EVT_W-1:0];
      end
      // the pending read clears first, so a drop in the same cycle lands in the fresh set A
      if (pend_rd) begin
         pend_a_nxt = '0;
         pend_b_nxt = '0;
      end
      // capture into the first free set, mask ignored
      if (i_drop.valid) begin
         if (!pend_a_nxt.valid) begin
            pend_a_nxt = '{reason: i_drop.reason, port: i_drop.port, valid: 1'b1};
         end else if (!pend_b_nxt.valid) begin
            pend_b_nxt = '{reason: i_drop.reason, port: i_drop.port, valid: 1'b1};
         end
         evt_nxt[`EVT_DROP_BIT] = 1'b1;
      end
      if (|i_learn_discard) begin
         evt_nxt[`EVT_LEARN_BIT] = 1'b1;
      end
      if (|sat_hit) begin
         evt_nxt[`EVT_SAT_BIT] = 1'b1;
      end
   end

   // the pending sets do not drive the line themselves; the drop status bit stands for
   // them, so a drop taken while masked still raises the line once the mask clears
   // global mask gates the one interrupt line
   always_comb begin
      irq_nxt = !mask_r && (|(evt_r & evt_en_r));
   end

   // register mask, status and interrupt
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mask_r <= `MASK_RESET;
         evt_en_r <= `EVT_ENABLE_RESET;
         pend_a_r <= '0;
         pend_b_r <= '0;
         evt_r <= '0;
         irq_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         evt_en_r <= evt_en_nxt;
         pend_a_r <= pend_a_nxt;
         pend_b_r <= pend_b_nxt;
         evt_r <= evt_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ==========================================
   // read data, one cycle after the strobe
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (i_rd) begin
         case (i_addr)
            `PORT0_PRIORITY_REGEN_MAP: rdata_nxt = {8'h00, map_r[0]};
            `PORT1_PRIORITY_REGEN_MAP: rdata_nxt = {8'h00, map_r[1]};
            `PORT2_PRIORITY_REGEN_MAP: rdata_nxt = {8'h00, map_r[2]};
            `PORT0_LEARN_DROP_COUNT: rdata_nxt = cnt_r[0];
            `PORT1_LEARN_DROP_COUNT: rdata_nxt = cnt_r[1];
            `PORT2_LEARN_DROP_COUNT: rdata_nxt = cnt_r[2];
            `SWITCH_IRQ_MASK: rdata_nxt = {31'h00000000, mask_r};
            // set B in bits 14:8, set A in bits 7:1, bit 0 reserved
            `SWITCH_IRQ_PENDING: rdata_nxt = {17'h00000, pend_b_r, pend_a_r, 1'b0};
            `ENGINE_EVENT_STATUS: rdata_nxt = {29'h00000000, evt_r};
            `ENGINE_EVENT_ENABLE: rdata_nxt = {29'h00000000, evt_en_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // register read data
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_queue_prio = queue_prio_r;
   assign o_irq = irq_r;

   // ==========================================
   // checks
   sequence map_read_s;
      i_rd && (i_addr >= 16'h1855) && (i_addr <= 16'h1857);
   endsequence

   sequence first_cycle_s;
      !$past(i_resetn);
   endsequence

   regen_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      first_cycle_s |-> (map_r[0] == 24'hfac688) && (map_r[1] == 24'hfac688) && (map_r[2] == 24'hfac688))
      else $error("regeneration table not identity after reset");

   // upper byte of a table reads zero
   map_reserved_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      map_read_s |=> o_rdata[31:24] == 8'h00)
      else $error("reserved table bits not zero");

   // mask register reads only bit 0
   mask_reserved_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_rd && (i_addr == 16'h1880) |=> (o_rdata[31:1] == 31'h0) && (o_rdata[0] == $past(mask_r)))
      else $error("mask register read wrong");

   irq_masked_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      mask_r |=> !o_irq)
      else $error("interrupt raised while masked");

   irq_unmask_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !mask_r && (|(evt_r & evt_en_r)) |=> o_irq)
      else $error("unmasked event not signalled");

   // drop captured into set A whatever the mask
   pend_capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_drop.valid && !pend_a_r.valid |=> pend_a_r.valid && (pend_a_r.reason == $past(i_drop.reason)))
      else $error("drop not captured in pending set A");

   // second drop goes to set B
   pend_second_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_drop.valid && pend_a_r.valid && !pend_b_r.valid && !pend_rd |=> pend_b_r.valid
         && (pend_b_r.port == $past(i_drop.port)) && $stable(pend_a_r))
      else $error("drop not captured in pending set B");

   // both sets full while a further drop arrives
   sequence pend_full_s;
      i_drop.valid && pend_a_r.valid && pend_b_r.valid && !pend_rd;
   endsequence

   // a drop with both sets full leaves them alone
   pend_full_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pend_full_s |=> $stable(pend_a_r) && $stable(pend_b_r))
      else $error("full pending sets overwritten");

   pend_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pend_rd && !i_drop.valid |=> !pend_a_r.valid && !pend_b_r.valid)
      else $error("pending sets not cleared by read");

   pend_layout_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      pend_rd |=> (o_rdata[31:15] == 17'h00000) && (o_rdata[14:8] == $past(pend_b_r))
         && (o_rdata[7:1] == $past(pend_a_r)) && (o_rdata[0] == 1'b0))
      else $error("pending register read layout wrong");

   // read data are zero outside the read answer
   rdata_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !i_rd |=> o_rdata == 32'h00000000)
      else $error("read data not zero without a read");

   irq_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(|(evt_r & evt_en_r)) |=> !o_irq)
      else $error("interrupt raised without enabled status");

   mask_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && (i_addr == `SWITCH_IRQ_MASK) |=> mask_r == $past(i_wdata[`MASK_BIT]))
      else $error("mask write not stored");

   // enable write takes the event bits
   enable_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_wr && (i_addr == `ENGINE_EVENT_ENABLE) |=> evt_en_r == $past(i_wdata[`EVT_W-1:0]))
      else $error("event enable write not stored");

   // a drop sets its status bit whatever the mask
   evt_drop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_drop.valid |=> evt_r[`EVT_DROP_BIT])
      else $error("drop status bit not set");

   // a learn discard sets its status bit
   evt_learn_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (|i_learn_discard) |=> evt_r[`EVT_LEARN_BIT])
      else $error("learn status bit not set");

   // status bits stay set until written
   evt_sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(i_wr && (i_addr == `ENGINE_EVENT_STATUS)) |=> (evt_r & $past(evt_r)) == $past(evt_r))
      else $error("status bit dropped without a write");

endmodule // switch_prio_stats

// ==== tb_switch_prio_stats.sv ====
// self-checking testbench of the switch engine register bank
`timescale 1ns/1ps
`include "switch_prio_stats_regs.svh"

module tb_switch_prio_stats
   import switch_prio_stats_pkg::*;
;
   // ==========================================
   // clock, reset and design inputs
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic [15:0] i_addr = 16'h0000;
   logic [31:0] i_wdata = 32'h00000000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   prio_req_t [2:0] i_rx_prio = '0;
   prio_req_t [2:0] o_queue_prio;
   logic [2:0] i_learn_discard = 3'h0;
   drop_evt_t i_drop = '0;
   logic o_irq;
   int error_cnt = 0;
   int num_checks = 0;
   logic [31:0] rv;

   always #4 i_clk = ~i_clk;

   switch_prio_stats #(.PORTS(3)) switch_prio_stats_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_prio(i_rx_prio), .o_queue_prio(o_queue_prio),
      .i_learn_discard(i_learn_discard), .i_drop(i_drop), .o_irq(o_irq)
   );

   // ==========================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // read data stand in the cycle after the strobe only
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic test_reset_values();
      for (int p = 0; p < 3; p++) begin
         rd(`PORT0_PRIORITY_REGEN_MAP + 16'(p), rv);
         check("map reset", rv, 32'h00fac688);
         rd(`PORT0_LEARN_DROP_COUNT + 16'(p), rv);
         check("count reset", rv, 32'h00000000);
      end
      rd(`SWITCH_IRQ_MASK, rv);
      check("mask reset", rv, 32'h00000001);
      rd(16'h1870, rv);
      check("unmapped read", rv, 32'h00000000);
      $display("test reset values done");
   endtask

   task automatic test_regen_map();
      logic [23:0] m;
      for (int p = 0; p < 3; p++) begin
         m = 24'h053977 ^ 24'(p * 24'h111111);
         wr(`PORT0_PRIORITY_REGEN_MAP + 16'(p), {8'hff, m});
         rd(`PORT0_PRIORITY_REGEN_MAP + 16'(p), rv);
         check("map reserved byte", rv, {8'h00, m});
         for (int n = 0; n < 8; n++) begin
            @(posedge i_clk);
            i_rx_prio[p] <= {1'b1, 3'(n)};
            @(posedge i_clk);
            i_rx_prio[p] <= '0;
            #1 check("queue prio", 32'(o_queue_prio[p]), 32'({1'b1, m[3*n +: 3]}));
         end
      end
      $display("test regen map done");
   endtask

   task automatic test_learn_count();
      for (int p = 0; p < 3; p++) begin
         // back-to-back pulses, one discard per cycle
         @(posedge i_clk);
         i_learn_discard[p] <= 1'b1;
         repeat (p + 2) @(posedge i_clk);
         i_learn_discard[p] <= 1'b0;
         rd(`PORT0_LEARN_DROP_COUNT + 16'(p), rv);
         check("discard count", rv, 32'(p + 2));
         rd(`PORT0_LEARN_DROP_COUNT + 16'(p), rv);
         check("count cleared", rv, 32'h00000000);
      end
      // clearing read meets a discard in the same cycle
      @(posedge i_clk);
      i_learn_discard[0] <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= `PORT0_LEARN_DROP_COUNT;
      @(posedge i_clk);
      i_rd <= 1'b0;
      i_learn_discard[0] <= 1'b0;
      #1 check("read with event", o_rdata, 32'h00000001);
      rd(`PORT0_LEARN_DROP_COUNT, rv);
      check("restart at one", rv, 32'h00000001);
      $display("test learn count done");
   endtask

   task automatic test_irq_mask();
      // only the learn discards of the counter test have raised a status bit so far
      rd(`ENGINE_EVENT_STATUS, rv);
      check("status after discards", rv, 32'h00000002);
      wr(`ENGINE_EVENT_STATUS, 32'h00000007);
      wr(`ENGINE_EVENT_ENABLE, 32'h00000001);
      @(posedge i_clk);
      i_drop <= {1'b1, 2'h1, 4'h3};
      @(posedge i_clk);
      i_drop <= '0;
      repeat (3) @(posedge i_clk);
      #1 check("irq while masked", 32'(o_irq), 32'h00000000);
      rd(`ENGINE_EVENT_STATUS, rv);
      check("status while masked", rv, 32'h00000001);
      rd(`SWITCH_IRQ_PENDING, rv);
      check("pending set a", rv, 32'h00000036);
      // two drops fill both sets, a third is lost from the pending sets
      @(posedge i_clk);
      i_drop <= {1'b1, 2'h2, 4'hb};
      @(posedge i_clk);
      i_drop <= {1'b1, 2'h0, 4'he};
      @(posedge i_clk);
      i_drop <= {1'b1, 2'h1, 4'h5};
      @(posedge i_clk);
      i_drop <= '0;
      rd(`SWITCH_IRQ_PENDING, rv);
      check("pending sets a and b", rv, 32'h000071ba);
      rd(`SWITCH_IRQ_PENDING, rv);
      check("pending cleared", rv, 32'h00000000);
      // reserved mask bits take no write
      wr(`SWITCH_IRQ_MASK, 32'hfffffffe);
      rd(`SWITCH_IRQ_MASK, rv);
      check("mask reserved", rv, 32'h00000000);
      repeat (2) @(posedge i_clk);
      #1 check("irq unmasked", 32'(o_irq), 32'h00000001);
      wr(`SWITCH_IRQ_MASK, 32'h00000001);
      repeat (2) @(posedge i_clk);
      #1 check("irq masked again", 32'(o_irq), 32'h00000000);
      $display("test irq mask done");
   endtask

   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      test_reset_values();
      test_regen_map();
      test_learn_count();
      test_irq_mask();
      print_verdict();
   end

   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
endmodule // tb_switch_prio_stats
